// ### pnr_pkg.sv
package pnr_pkg;

    // register offsets in the data memory window of the port block
    localparam logic [2:0] PNR_OFS_DATA = 3'h0;
    localparam logic [2:0] PNR_OFS_DIR = 3'h1;
    localparam logic [2:0] PNR_OFS_PULLUP = 3'h2;
    localparam logic [2:0] PNR_OFS_WAKE = 3'h3;
    localparam logic [2:0] PNR_OFS_REMAP = 3'h4;
    localparam logic [2:0] PNR_OFS_ANALOG = 3'h5;

    // values after reset
    localparam logic [7:0] PNR_DATA_RST = 8'hFF;
    localparam logic [7:0] PNR_DIR_RST = 8'hFF;
    localparam logic [7:0] PNR_PULLUP_RST = 8'h00;
    localparam logic [7:0] PNR_WAKE_RST = 8'h00;
    localparam logic [3:0] PNR_KEY_RST = 4'h5;
    localparam logic [2:0] PNR_SEL_RST = 3'h0;
    localparam logic [7:0] PNR_ANALOG_RST = 8'hFF;

    // remap register layout
    localparam logic [3:0] PNR_KEY_OPEN = 4'hA;
    localparam int PNR_KEY_LSB = 4;
    localparam int PNR_UNIMPL_BIT = 3;
    localparam int PNR_IRQ_SEL_BIT = 2;

    // line numbers used by the routing table
    localparam logic [2:0] PNR_LINE0 = 3'h0;
    localparam logic [2:0] PNR_LINE1 = 3'h1;
    localparam logic [2:0] PNR_LINE2 = 3'h2;
    localparam logic [2:0] PNR_LINE3 = 3'h3;
    localparam logic [2:0] PNR_LINE4 = 3'h4;
    localparam logic [2:0] PNR_LINE5 = 3'h5;
    localparam logic [2:0] PNR_LINE6 = 3'h6;
    localparam logic [2:0] PNR_LINE7 = 3'h7;

    typedef struct packed {
        logic wr;            // byte write
        logic rd;            // byte read
        logic bit_op;        // single-bit set or clear
        logic [2:0] bit_idx; // bit chosen by bit_op
        logic bit_val;       // 1 sets, 0 clears
        logic [2:0] addr;    // register offset
        logic [7:0] wdata;   // byte write data
    } pnr_req_t;

    typedef struct packed {
        logic out_a;
        logic out_b;
        logic c_main;
        logic c_alt;
    } pnr_tmr_t;

    typedef struct packed {
        logic [2:0] irq;
        logic [2:0] out_a;
        logic [2:0] out_b;
        logic [2:0] c_main;
        logic [2:0] c_alt;
    } pnr_pos_t;

endpackage

// ### pnr_route.sv
`timescale 1ns/1ps
module pnr_route
    import pnr_pkg::*;
(
    input wire logic [2:0] sel,         // remap selection bits
    input wire logic three_timer,       // 1 for the three-timer variant
    output pnr_pos_t pos                // line of each routed function
);

    always_comb
    begin
        pos.irq = sel[PNR_IRQ_SEL_BIT] ? PNR_LINE7 : PNR_LINE3;
        unique case (sel[1:0])
            2'h0:
            begin
                pos.out_a = PNR_LINE3;
                pos.out_b = PNR_LINE4;
                pos.c_alt = PNR_LINE5;
                pos.c_main = PNR_LINE6;
            end
            2'h1:
            begin
                pos.out_a = PNR_LINE3;
                pos.out_b = PNR_LINE4;
                pos.c_alt = three_timer ? PNR_LINE0 : PNR_LINE5;
                pos.c_main = three_timer ? PNR_LINE1 : PNR_LINE6;
            end
            2'h2:
            begin
                pos.out_a = PNR_LINE5;
                pos.out_b = PNR_LINE6;
                pos.c_alt = PNR_LINE2;
                pos.c_main = PNR_LINE7;
            end
            2'h3:
            begin
                pos.out_a = PNR_LINE2;
                pos.out_b = PNR_LINE7;
                pos.c_alt = PNR_LINE5;
                pos.c_main = PNR_LINE6;
            end
        endcase
    end

endmodule // pnr_route

// ### pnr_port.sv
`timescale 1ns/1ps
// Operation
// - direction bit 0 makes the line an output, 1 an input
// - remap key resets to 0101; selection writes only when key is 1010
// - remap bit 3 is unimplemented and reads zero
// - remap bit 2 puts interrupt and clock b on line 7, else line 3
// - two-timer code 0x: output a on 3, output b/clock a on 4
// - two-timer code 10: lines 5 and 6; code 11: lines 2 and 7
// - three-timer code 00: a/clock c 3, b/clock a 4, alt 5, main 6
// - three-timer code 01: lines 3,4 as 00; alt on 0, main on 1
// - three-timer code 10: 5,6,2,7; code 11: 2,7,5,6
// - analog function wins over digital function on the same pin
// - pin goes to every active analog module at once
// - data and direction registers reset to all ones, lines are inputs
// - a new output drives its data latch, high after reset
// - bit set or clear reads whole port, modifies bit, writes byte back
// - converter-shared pins reset to analog with converter kept off
// - enabled converter channel disconnects the pull-up on that pin
// - in sleep or idle, falling edge on wake-enabled line wakes device
// - wake enable register has one enable bit per line
// - pull-up enable bit connects weak pull-up while line is input
// - reading an output line returns its data latch, not the pin
module pnr_port
    import pnr_pkg::*;
#(
    parameter bit THREE_TIMER = 1'b0     // three-timer variant when set
)
(
    input wire logic ref_clk,            // system clock
    input wire logic arst_n,             // async reset, active low
    input pnr_req_t req,                 // register access request
    output logic [7:0] rdata,            // read data, one cycle after rd
    input wire logic [7:0] pin_in,       // pin levels
    output logic [7:0] pin_out,          // pin output levels
    output logic [7:0] pin_oe_n,         // 0 while the line is driven
    output logic [7:0] pullup_en,        // weak pull-up connect per line
    output logic [7:0] analog_conn,      // pin connected to analog modules
    input pnr_tmr_t tmr_val,             // timer output levels
    input pnr_tmr_t tmr_en,              // timer output functions enabled
    output logic timer_clock_in_a,       // routed timer clock a
    output logic timer_clock_in_b,       // routed timer clock b
    output logic timer_clock_in_c,       // routed timer clock c
    output logic ext_irq_in,             // routed external interrupt input
    input wire logic sleep_mode,         // device is in sleep or idle
    output logic wake_up                 // wake pulse, one cycle
);

    logic [7:0] port_data_reg_q;
    logic [7:0] port_direction_reg_q;
    logic [7:0] pullup_enable_reg_q;
    logic [7:0] wake_enable_reg_q;
    logic [3:0] remap_lock_key_q;
    logic irq_clock_route_sel_q;
    logic [1:0] timer_out_route_sel_q;
    logic [7:0] analog_sel_q;
    logic [7:0] pin_prev_q;
    logic [7:0] rd_view;
    logic [7:0] port_read;
    logic [7:0] rmw_byte;
    logic wr_do;
    logic [7:0] wr_byte;
    logic [7:0] tmr_drv;
    logic [7:0] tmr_lvl;
    logic [7:0] pin_out_d;
    logic [7:0] pin_oe_n_d;
    pnr_pos_t pos;

    pnr_route u_route
    (
        .sel({irq_clock_route_sel_q, timer_out_route_sel_q}),
        .three_timer(THREE_TIMER),
        .pos(pos)
    );

    // output lines read back their latch
    always_comb
    begin
        for (int k = 0; k < 8; k++)
        begin
            port_read[k] = port_direction_reg_q[k] ? pin_in[k]
                                                   : port_data_reg_q[k];
        end
    end

    always_comb
    begin
        unique case (req.addr)
            PNR_OFS_DATA: rd_view = port_read;
            PNR_OFS_DIR: rd_view = port_direction_reg_q;
            PNR_OFS_PULLUP: rd_view = pullup_enable_reg_q;
            PNR_OFS_WAKE: rd_view = wake_enable_reg_q;
            PNR_OFS_REMAP: rd_view = {remap_lock_key_q, 1'b0,
                irq_clock_route_sel_q, timer_out_route_sel_q};
            PNR_OFS_ANALOG: rd_view = analog_sel_q;
            default: rd_view = 8'h00;
        endcase
    end

    // bit operation: whole byte read, one bit changed, byte written back
    always_comb
    begin
        rmw_byte = rd_view;
        rmw_byte[req.bit_idx] = req.bit_val;
    end

    assign wr_do = req.wr | req.bit_op;
    assign wr_byte = req.bit_op ? rmw_byte : req.wdata;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= 8'h00;
        else if (req.rd)
            rdata <= rd_view;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            port_data_reg_q <= PNR_DATA_RST;
        else if (wr_do && req.addr == PNR_OFS_DATA)
            port_data_reg_q <= wr_byte;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            port_direction_reg_q <= PNR_DIR_RST;
        else if (wr_do && req.addr == PNR_OFS_DIR)
            port_direction_reg_q <= wr_byte;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            pullup_enable_reg_q <= PNR_PULLUP_RST;
        else if (wr_do && req.addr == PNR_OFS_PULLUP)
            pullup_enable_reg_q <= wr_byte;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            wake_enable_reg_q <= PNR_WAKE_RST;
        else if (wr_do && req.addr == PNR_OFS_WAKE)
            wake_enable_reg_q <= wr_byte;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            analog_sel_q <= PNR_ANALOG_RST;
        else if (wr_do && req.addr == PNR_OFS_ANALOG)
            analog_sel_q <= wr_byte;
    end

    // key field always takes the write
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            remap_lock_key_q <= PNR_KEY_RST;
        else if (wr_do && req.addr == PNR_OFS_REMAP)
            remap_lock_key_q <= wr_byte[7:PNR_KEY_LSB];
    end

    // selections only move while the old key reads open
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_clock_route_sel_q <= PNR_SEL_RST[2];
            timer_out_route_sel_q <= PNR_SEL_RST[1:0];
        end
        else if (wr_do && req.addr == PNR_OFS_REMAP
                 && remap_lock_key_q == PNR_KEY_OPEN)
        begin
            irq_clock_route_sel_q <= wr_byte[PNR_IRQ_SEL_BIT];
            timer_out_route_sel_q <= wr_byte[1:0];
        end
    end

    // per-line pin function priority: analog, timer, port latch
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_line
            logic hit_a;
            logic hit_b;
            logic hit_m;
            logic hit_c;
            assign hit_a = tmr_en.out_a && pos.out_a == 3'(i);
            assign hit_b = tmr_en.out_b && pos.out_b == 3'(i);
            assign hit_m = THREE_TIMER && tmr_en.c_main
                           && pos.c_main == 3'(i);
            assign hit_c = THREE_TIMER && tmr_en.c_alt
                           && pos.c_alt == 3'(i);
            assign tmr_drv[i] = hit_a | hit_b | hit_m | hit_c;
            assign tmr_lvl[i] = (hit_a & tmr_val.out_a)
                                | (hit_b & tmr_val.out_b)
                                | (hit_m & tmr_val.c_main)
                                | (hit_c & tmr_val.c_alt);
            always_comb
            begin
                if (analog_sel_q[i])
                begin
                    pin_oe_n_d[i] = 1'b1;
                    pin_out_d[i] = 1'b0;
                end
                else if (tmr_drv[i])
                begin
                    pin_oe_n_d[i] = 1'b0;
                    pin_out_d[i] = tmr_lvl[i];
                end
                else
                begin
                    pin_oe_n_d[i] = port_direction_reg_q[i];
                    pin_out_d[i] = port_data_reg_q[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_oe_n <= 8'hFF;
            pin_out <= PNR_DATA_RST;
            pullup_en <= 8'h00;
            analog_conn <= 8'h00;
        end
        else
        begin
            pin_oe_n <= pin_oe_n_d;
            pin_out <= pin_out_d;
            pullup_en <= pullup_enable_reg_q & pin_oe_n_d
                         & ~analog_sel_q;
            analog_conn <= analog_sel_q;
        end
    end

    // routed inputs, registered once
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext_irq_in <= 1'b1;
            timer_clock_in_a <= 1'b0;
            timer_clock_in_b <= 1'b0;
            timer_clock_in_c <= 1'b0;
        end
        else
        begin
            ext_irq_in <= pin_in[pos.irq];
            timer_clock_in_b <= pin_in[pos.irq];
            timer_clock_in_a <= pin_in[pos.out_b];
            timer_clock_in_c <= THREE_TIMER & pin_in[pos.out_a];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_prev_q <= 8'hFF;
            wake_up <= 1'b0;
        end
        else
        begin
            pin_prev_q <= pin_in;
            wake_up <= sleep_mode
                       && |(wake_enable_reg_q & pin_prev_q & ~pin_in);
        end
    end

    sequence remap_wr_s;
        req.wr && !req.bit_op && req.addr == PNR_OFS_REMAP;
    endsequence

    property locked_hold_p;
        @(posedge ref_clk) disable iff (!arst_n)
        (remap_wr_s and remap_lock_key_q != PNR_KEY_OPEN)
        |=> $stable({irq_clock_route_sel_q, timer_out_route_sel_q});
    endproperty
    remap_lock_a: assert property (locked_hold_p)
        else $error("remap selection changed while locked");

    property unlock_write_p;
        @(posedge ref_clk) disable iff (!arst_n)
        (remap_wr_s and remap_lock_key_q == PNR_KEY_OPEN)
        |=> timer_out_route_sel_q == $past(req.wdata[1:0]);
    endproperty
    remap_unlock_a: assert property (unlock_write_p)
        else $error("open remap write not taken");

    key_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        remap_wr_s |=> remap_lock_key_q == $past(req.wdata[7:4]))
        else $error("lock key not written");

    unimpl_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.rd && req.addr == PNR_OFS_REMAP |=> !rdata[3])
        else $error("remap bit 3 read as one");

    irq_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        irq_clock_route_sel_q |=> ext_irq_in == $past(pin_in[7]))
        else $error("interrupt not taken from line 7");

    analog_prio_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        analog_sel_q[3] |=> pin_oe_n[3] && !pullup_en[3])
        else $error("analog pin driven or pulled up");

    wake_edge_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sleep_mode && wake_enable_reg_q[0] && pin_prev_q[0] && !pin_in[0]
        |=> wake_up)
        else $error("falling edge did not wake");

    readback_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.rd && req.addr == PNR_OFS_DATA && port_direction_reg_q == 8'h00
        |=> rdata == $past(port_data_reg_q))
        else $error("output line did not read its latch");

    dir_input_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        port_direction_reg_q == 8'hFF && tmr_en == 4'h0
        |=> pin_oe_n == 8'hFF)
        else $error("input line driven");

    sequence dir_bitop_s;
        req.bit_op && !req.wr && req.addr == PNR_OFS_DIR;
    endsequence

    bit_op_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        dir_bitop_s |=> port_direction_reg_q[$past(req.bit_idx)]
                        == $past(req.bit_val))
        else $error("bit operation lost");

endmodule // pnr_port

// ### pnr_pins_model.sv
`timescale 1ns/1ps
module pnr_pins_model
    import pnr_pkg::*;
(
    input wire logic ref_clk,        // system clock
    input wire logic [7:0] pin_out,  // device levels
    input wire logic [7:0] pin_oe_n, // 0 while device drives
    input wire logic [7:0] pull_en,  // weak pull-up connected
    input wire logic [7:0] ext_en,   // lines driven from outside
    input wire logic [7:0] ext_val,  // outside levels
    output logic [7:0] pin_in        // resolved pin levels
);
    logic flip_q = 1'b0;
    always_ff @(posedge ref_clk)
    begin
        flip_q <= ~flip_q;
    end
    // floating lines wander so no stale level passes
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (pull_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flip_q ^ i[0];
        end
    end
endmodule // pnr_pins_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pnr_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    pnr_req_t req = '0;
    pnr_tmr_t tmr_val = '0;
    pnr_tmr_t tmr_en = '0;
    logic sleep_mode = 1'b0;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] pin_in, pin_out, pin_oe_n, pull_en, rdata, an;
    logic [7:0] oe3, m;
    logic ck_a, ck_b, ck_c, irq, wake_up, seen;
    logic irq3, ck_c3;
    logic [14:0] e, e3;
    int fail_count = 0;
    int tests_run = 0;

    always #10 ref_clk = ~ref_clk;

    pnr_port #(.THREE_TIMER(1'b0)) i_dut (.ref_clk(ref_clk),
        .arst_n(arst_n), .req(req), .rdata(rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pull_en),
        .analog_conn(an), .tmr_val(tmr_val), .tmr_en(tmr_en),
        .timer_clock_in_a(ck_a), .timer_clock_in_b(ck_b),
        .timer_clock_in_c(ck_c), .ext_irq_in(irq),
        .sleep_mode(sleep_mode), .wake_up(wake_up));
    // three-timer variant sharing the register bus, pins straight from outside
    pnr_port #(.THREE_TIMER(1'b1)) i_dut3 (.ref_clk(ref_clk),
        .arst_n(arst_n), .req(req), .rdata(), .pin_in(ext_val),
        .pin_out(), .pin_oe_n(oe3), .pullup_en(), .analog_conn(),
        .tmr_val(tmr_val), .tmr_en(tmr_en), .timer_clock_in_a(),
        .timer_clock_in_b(), .timer_clock_in_c(ck_c3),
        .ext_irq_in(irq3), .sleep_mode(sleep_mode), .wake_up());
    pnr_pins_model i_pins (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pull_en(pull_en), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    task automatic ck(input string nm, input logic [7:0] x,
        input logic [7:0] g);
        tests_run++;
        if (g !== x)
        begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, x, g);
        end
    endtask
    task automatic acc(input int k, input logic [2:0] a,
        input logic [7:0] d);
        @(negedge ref_clk);
        req = '{wr:k == 0, rd:k == 1, bit_op:k == 2, bit_idx:d[2:0],
            bit_val:d[3], addr:a, wdata:d};
        @(negedge ref_clk);
        req = '0;
    endtask
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        acc(0, a, d);
    endtask
    task automatic r(input string nm, input logic [2:0] a,
        input logic [7:0] x);
        acc(1, a, 8'h00);
        ck(nm, x, rdata);
    endtask
    task automatic st(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic watch(input int n);
        seen = 1'b0;
        repeat (n)
        begin
            @(negedge ref_clk);
            if (wake_up === 1'b1)
                seen = 1'b1;
        end
    endtask
    function automatic logic [14:0] exp_pos(input logic t,
        input logic [2:0] s);
        logic [2:0] q;
        q = s[2] ? 3'h7 : 3'h3;
        case (s[1:0])
            2'b00: return {q, 12'o3465};
            2'b01: return t ? {q, 12'o3410} : {q, 12'o3465};
            2'b10: return {q, 12'o5672};
            default: return {q, 12'o2765};
        endcase
    endfunction

    task automatic t_reset();
        ext_en = 8'hFF;
        ext_val = 8'h3C;
        r("data", PNR_OFS_DATA, 8'h3C);
        r("dir", PNR_OFS_DIR, 8'hFF);
        r("pull", PNR_OFS_PULLUP, 8'h00);
        r("wake", PNR_OFS_WAKE, 8'h00);
        r("remap", PNR_OFS_REMAP, 8'h50);
        r("analog", PNR_OFS_ANALOG, 8'hFF);
        r("hole", 3'h6, 8'h00);
        ext_en = 8'h00;
        $display("test reset done");
    endtask
    task automatic t_lock();
        w(PNR_OFS_REMAP, 8'h07);
        r("locked", PNR_OFS_REMAP, 8'h00);
        w(PNR_OFS_REMAP, 8'hA0);
        r("key", PNR_OFS_REMAP, 8'hA0);
        w(PNR_OFS_REMAP, 8'hAF);
        r("open", PNR_OFS_REMAP, 8'hA7);
        w(PNR_OFS_REMAP, 8'h5B);
        r("relock", PNR_OFS_REMAP, 8'h53);
        w(PNR_OFS_REMAP, 8'h51);
        r("shut", PNR_OFS_REMAP, 8'h53);
        w(PNR_OFS_REMAP, 8'hA0);
        w(PNR_OFS_REMAP, 8'hA0);
        $display("test lock done");
    endtask
    task automatic t_dir();
        w(PNR_OFS_PULLUP, 8'hFF);
        w(PNR_OFS_DIR, 8'h00);
        st(3);
        ck("oe analog", 8'hFF, pin_oe_n);
        ck("an conn", 8'hFF, an);
        ck("pull off", 8'h00, pull_en);
        w(PNR_OFS_ANALOG, 8'h00);
        st(3);
        ck("oe", 8'h00, pin_oe_n);
        ck("latch", 8'hFF, pin_out);
        ck("pull drv", 8'h00, pull_en);
        w(PNR_OFS_DIR, 8'hF0);
        st(3);
        ck("oe half", 8'hF0, pin_oe_n);
        ck("pull in", 8'hF0, pull_en);
        w(PNR_OFS_PULLUP, 8'h00);
        $display("test dir done");
    endtask
    task automatic t_rmw();
        ext_en = 8'hFF;
        ext_val = 8'hA3;
        w(PNR_OFS_DIR, 8'h0F);
        w(PNR_OFS_DATA, 8'h05);
        r("rdback", PNR_OFS_DATA, 8'h03);
        acc(2, PNR_OFS_DATA, 8'h0A);
        ext_en = 8'h00;
        w(PNR_OFS_DIR, 8'h00);
        st(3);
        ck("rmw data", 8'h07, pin_out);
        w(PNR_OFS_DIR, 8'hFF);
        acc(2, PNR_OFS_DIR, 8'h03);
        r("rmw dir", PNR_OFS_DIR, 8'hF7);
        w(PNR_OFS_DIR, 8'hFF);
        $display("test rmw done");
    endtask
    task automatic t_table();
        for (int s = 0; s < 8; s++)
        begin
            e = exp_pos(1'b0, s[2:0]);
            e3 = exp_pos(1'b1, s[2:0]);
            w(PNR_OFS_REMAP, {5'h14, s[2:0]});
            ext_en = 8'hFF;
            ext_val = 8'h01 << e[14:12];
            st(3);
            ck("irq", 8'h01, {7'h0, irq});
            ck("irq3", 8'h01, {7'h0, irq3});
            ck("clk b", 8'h01, {7'h0, ck_b});
            ck("clk a", {7'h0, e[8:6] == e[14:12]}, {7'h0, ck_a});
            ck("clk c", 8'h00, {7'h0, ck_c});
            ck("ckc3", {7'h0, e3[11:9] == e3[14:12]}, {7'h0, ck_c3});
            for (int f = 0; f < 4; f++)
            begin
                tmr_en = pnr_tmr_t'(4'h8 >> f);
                st(3);
                m = f < 2 ? ~(8'h01 << e[11 - 3 * f -: 3]) : 8'hFF;
                ck("oe two", m, pin_oe_n);
                m = ~(8'h01 << e3[11 - 3 * f -: 3]);
                ck("oe three", m, oe3);
            end
        end
        tmr_en = '0;
        ext_en = 8'h00;
        $display("test table done");
    endtask
    task automatic t_route();
        w(PNR_OFS_REMAP, 8'hA6);
        tmr_en.out_a = 1'b1;
        tmr_val.out_a = 1'b1;
        st(3);
        ck("tp oe", 8'hDF, pin_oe_n);
        ck("tp hi", 8'h20, pin_out & 8'h20);
        tmr_val.out_a = 1'b0;
        ext_en = 8'hC0;
        ext_val = 8'h80;
        st(3);
        ck("tp lo", 8'h00, pin_out & 8'h20);
        ck("irq7", 8'h01, {7'h0, irq});
        ck("clk b", 8'h01, {7'h0, ck_b});
        ck("clk a", 8'h00, {7'h0, ck_a});
        tmr_en = '0;
        ext_en = 8'h00;
        w(PNR_OFS_REMAP, 8'hA0);
        $display("test route done");
    endtask
    task automatic t_wake();
        w(PNR_OFS_WAKE, 8'h01);
        ext_en = 8'h03;
        ext_val = 8'h03;
        sleep_mode = 1'b1;
        st(3);
        ext_val = 8'h02;
        watch(4);
        ck("wake", 8'h01, {7'h0, seen});
        ext_val = 8'h00;
        watch(4);
        ck("no wake", 8'h00, {7'h0, seen});
        sleep_mode = 1'b0;
        ext_val = 8'h01;
        st(2);
        ext_val = 8'h00;
        watch(4);
        ck("awake", 8'h00, {7'h0, seen});
        $display("test wake done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #100us;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        st(5);
        arst_n = 1'b1;
        t_reset();
        t_lock();
        t_dir();
        t_rmw();
        t_table();
        t_route();
        t_wake();
        report_and_stop();
    end
endmodule // tb_top
